//--- hdl/pll_divider_lock_detect.sv
// Contract
// - Reference divider is 14 bits, 0..16383.
// - Reference divide of 0 or 1 passes through.
// - Ref and feedback dividers feed phase detector.
// - Ref counter reset by own, shared, sync.
// - Feedback ratio is P times B plus A.
// - Mode field picks fixed or dual modulus.
// - Fixed mode ignores A count.
// - A count of zero swallows nothing.
// - A/B counters reset by own, shared, sync.
// - Enabled sync pin resets R, A and B counters, not the prescaler; default off.
// - Each divider path has enableable 3-bit delay.
// - Edge gap below lock threshold qualifies cycle.
// - Unlock threshold wider than lock threshold.
// - Lock after programmable consecutive in-lock cycles.
// - Single cycle beyond unlock threshold drops lock.
// - Windows depend on range bit and antibacklash.
// - Lock indication muxed onto three pins.
// - Lock pin selector offers current-source mode.
// - Current mode sources on lock, grounds otherwise.
// - Pin comparator to monitor/status, either polarity.
// - Counter code 00 requires five cycles.
// - Window bit zero selects high range.
`timescale 1ns/10ps
module pll_divider_lock_detect #(
	parameter logic [pll_div_pkg::PH_W-1:0] LOCK_THR_HIGH = pll_div_pkg::LOCK_THR_HIGH_DEF,
	parameter logic [pll_div_pkg::PH_W-1:0] LOCK_THR_LOW = pll_div_pkg::LOCK_THR_LOW_DEF,
	parameter logic [pll_div_pkg::PH_W-1:0] UNLOCK_MARGIN = pll_div_pkg::UNLOCK_MARGIN_DEF,
	parameter logic [pll_div_pkg::CHG_W-1:0] CHARGE_TERM = pll_div_pkg::CHARGE_TERM_DEF
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [pll_div_pkg::ADDR_W-1:0] addr,
	input wire logic [pll_div_pkg::DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [pll_div_pkg::DATA_W-1:0] rdata,
	input wire logic ref_clk_in,
	input wire logic vco_clk_in,
	input wire logic nsync_pin,
	output logic pfd_ref_pulse,
	output logic pfd_fb_pulse,
	output logic digital_lock_indicator,
	output logic lock_indicator_pin,
	output logic status_pin,
	output logic reference_monitor_pin
);
	import pll_div_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Parameter check
	generate
		if (LOCK_THR_LOW == '0 || LOCK_THR_HIGH < LOCK_THR_LOW || UNLOCK_MARGIN == '0 ||
			CHARGE_TERM == '0 || {1'b0, LOCK_THR_HIGH} + 9'h003 + {1'b0, UNLOCK_MARGIN} > 9'h0fe) begin : g_bad
			$error("pll_divider_lock_detect: threshold parameters out of range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [1:0] ref_sync;
		logic [1:0] vco_sync;
		logic [1:0] nsync_sync;
		logic ref_prev;
		logic vco_prev;
		logic [R_W-1:0] r_div;
		logic [A_W-1:0] a_cfg;
		logic [B_W-1:0] b_cfg;
		logic [2:0] presc_mode;
		logic rst_ab;
		logic rst_r;
		logic rst_all;
		logic [1:0] abp;
		logic [5:0] status_sel;
		logic [1:0] ld_count;
		logic ld_window;
		logic dld_off;
		logic [1:0] sync_ctl;
		logic [2:0] r_dly;
		logic [2:0] n_dly;
		logic r_dly_en;
		logic n_dly_en;
		logic [5:0] ld_sel;
		logic [4:0] reference_monitor_pin_sel;
		logic [R_W-1:0] r_cnt;
		logic [PRE_W-1:0] pre_cnt;
		logic [A_W-1:0] a_left;
		logic [B_W-1:0] b_cnt;
		logic [DLY_TAPS-1:0] ref_line;
		logic [DLY_TAPS-1:0] fb_line;
		logic pfd_ref;
		logic pfd_fb;
		phase_e phase;
		logic [PH_W-1:0] phase_cnt;
		logic [PH_W-1:0] consec;
		logic lock;
		logic [CHG_W-1:0] charge;
		logic ld_pin;
		logic status_pin;
		logic reference_monitor_pin_pin;
		logic [DATA_W-1:0] rdata;
	} state_s;

	state_s st_reg;
	state_s st_next;

	logic ref_edge;
	logic vco_edge;
	logic sync_hold;
	logic r_clear;
	logic ab_clear;
	logic r_raw;
	logic pre_tick;
	logic fb_raw;
	logic dual_mode;
	logic [PRE_W-1:0] p_base;
	logic [PRE_W-1:0] modulus;
	logic [B_W-1:0] b_eff;
	logic [A_W-1:0] a_load;
	logic [PH_W-1:0] lock_thr;
	logic [PH_W-1:0] unlock_thr;
	logic [PH_W-1:0] lock_target;
	logic [PH_W-1:0] ph_diff;
	logic ph_eval;
	logic ph_other;
	logic ph_same;
	logic cs_mode;
	logic cmp_level;
	logic [DATA_W-1:0] rd_value;

	function automatic logic pin_mux(input logic [5:0] sel, input logic lk, input logic cmp,
		input logic pr, input logic pf);
		case (sel)
			SEL_DLD: pin_mux = lk;
			SEL_DLD_N: pin_mux = ~lk;
			SEL_CMP: pin_mux = cmp;
			SEL_CMP_N: pin_mux = ~cmp;
			SEL_PFD_REF: pin_mux = pr;
			SEL_PFD_FB: pin_mux = pf;
			default: pin_mux = 1'b0;
		endcase
	endfunction

	always_comb begin
		st_next = st_reg;

		////////////////////////////////////////////////////////////////////
		// Pin synchronisers; only the second stage is looked at
		st_next.ref_sync = {st_reg.ref_sync[0], ref_clk_in};
		st_next.vco_sync = {st_reg.vco_sync[0], vco_clk_in};
		st_next.nsync_sync = {st_reg.nsync_sync[0], nsync_pin};
		st_next.ref_prev = st_reg.ref_sync[1];
		st_next.vco_prev = st_reg.vco_sync[1];
		ref_edge = st_reg.ref_sync[1] & ~st_reg.ref_prev;
		vco_edge = st_reg.vco_sync[1] & ~st_reg.vco_prev;

		sync_hold = (st_reg.sync_ctl != SYNC_OFF) && !st_reg.nsync_sync[1];
		r_clear = st_reg.rst_r | st_reg.rst_all | sync_hold;
		ab_clear = st_reg.rst_ab | st_reg.rst_all | sync_hold;

		////////////////////////////////////////////////////////////////////
		// Reference divider
		r_raw = 1'b0;
		if (r_clear) begin
			st_next.r_cnt = '0;
		end else if (ref_edge) begin
			if (st_reg.r_div <= R_W'(1)) begin
				r_raw = 1'b1;
			end else if (st_reg.r_cnt >= st_reg.r_div - R_W'(1)) begin
				r_raw = 1'b1;
				st_next.r_cnt = '0;
			end else begin
				st_next.r_cnt = st_reg.r_cnt + R_W'(1);
			end
		end

		////////////////////////////////////////////////////////////////////
		// Prescaler decode
		// fixed or dual modulus
		case (st_reg.presc_mode)
			PRESC_FD1: begin
				p_base = PRE_W'(1);
				dual_mode = 1'b0;
			end
			PRESC_FD2: begin
				p_base = PRE_W'(2);
				dual_mode = 1'b0;
			end
			PRESC_FD3: begin
				p_base = PRE_W'(3);
				dual_mode = 1'b0;
			end
			PRESC_DM2: begin
				p_base = PRE_W'(2);
				dual_mode = 1'b1;
			end
			PRESC_DM4: begin
				p_base = PRE_W'(4);
				dual_mode = 1'b1;
			end
			PRESC_DM8: begin
				p_base = PRE_W'(8);
				dual_mode = 1'b1;
			end
			PRESC_DM16: begin
				p_base = PRE_W'(16);
				dual_mode = 1'b1;
			end
			default: begin
				p_base = PRE_W'(32);
				dual_mode = 1'b1;
			end
		endcase

		// A forced to zero in fixed mode
		a_load = dual_mode ? st_reg.a_cfg : '0;
		// swallow one extra edge while A remains
		modulus = p_base + PRE_W'(dual_mode && st_reg.a_left != '0);

		// Prescaler is cleared only by nrst, so its phase carries across counter resets
		pre_tick = 1'b0;
		if (vco_edge) begin
			if (st_reg.pre_cnt >= modulus - PRE_W'(1)) begin
				pre_tick = 1'b1;
				st_next.pre_cnt = '0;
			end else begin
				st_next.pre_cnt = st_reg.pre_cnt + PRE_W'(1);
			end
		end

		////////////////////////////////////////////////////////////////////
		// A and B counters
		// B of 0 or 1 treated as bypass
		b_eff = (st_reg.b_cfg == '0) ? B_W'(1) : st_reg.b_cfg;
		fb_raw = 1'b0;
		if (ab_clear) begin
			st_next.b_cnt = '0;
			st_next.a_left = a_load;
		end else if (pre_tick) begin
			if (st_reg.a_left != '0) begin
				st_next.a_left = st_reg.a_left - A_W'(1);
			end
			// period is P*B + A input edges
			if (st_reg.b_cnt >= b_eff - B_W'(1)) begin
				fb_raw = 1'b1;
				st_next.b_cnt = '0;
				st_next.a_left = a_load;
			end else begin
				st_next.b_cnt = st_reg.b_cnt + B_W'(1);
			end
		end

		////////////////////////////////////////////////////////////////////
		// Path delay cells, whole mclk steps; an enabled code 0 costs one cycle
		st_next.ref_line = {st_reg.ref_line[DLY_TAPS-2:0], r_raw};
		st_next.fb_line = {st_reg.fb_line[DLY_TAPS-2:0], fb_raw};
		st_next.pfd_ref = st_reg.r_dly_en ? st_reg.ref_line[st_reg.r_dly] : r_raw;
		st_next.pfd_fb = st_reg.n_dly_en ? st_reg.fb_line[st_reg.n_dly] : fb_raw;

		////////////////////////////////////////////////////////////////////
		// Lock windows
		// range bit plus antibacklash
		lock_thr = (st_reg.ld_window ? LOCK_THR_LOW : LOCK_THR_HIGH) + PH_W'(st_reg.abp);
		unlock_thr = lock_thr + UNLOCK_MARGIN;
		case (st_reg.ld_count)
			2'h0: lock_target = LOCK_CNT_0;
			2'h1: lock_target = LOCK_CNT_1;
			2'h2: lock_target = LOCK_CNT_2;
			default: lock_target = LOCK_CNT_3;
		endcase

		////////////////////////////////////////////////////////////////////
		// Edge gap measurement between the two detector inputs
		ph_eval = 1'b0;
		ph_diff = '0;
		ph_other = (st_reg.phase == PH_WAIT_FB) ? st_reg.pfd_fb : st_reg.pfd_ref;
		ph_same = (st_reg.phase == PH_WAIT_FB) ? st_reg.pfd_ref : st_reg.pfd_fb;
		case (st_reg.phase)
			PH_IDLE: begin
				if (st_reg.pfd_ref && st_reg.pfd_fb) begin
					ph_eval = 1'b1;
				end else if (st_reg.pfd_ref) begin
					st_next.phase = PH_WAIT_FB;
					st_next.phase_cnt = PH_W'(1);
				end else if (st_reg.pfd_fb) begin
					st_next.phase = PH_WAIT_REF;
					st_next.phase_cnt = PH_W'(1);
				end
			end
			PH_WAIT_FB, PH_WAIT_REF: begin
				if (ph_other) begin
					ph_eval = 1'b1;
					ph_diff = st_reg.phase_cnt;
					st_next.phase = PH_IDLE;
				end else if (ph_same) begin
					// A second edge on the same side means the other is missing
					ph_eval = 1'b1;
					ph_diff = '1;
					st_next.phase_cnt = PH_W'(1);
				end else if (st_reg.phase_cnt > unlock_thr) begin
					ph_eval = 1'b1;
					ph_diff = st_reg.phase_cnt;
					st_next.phase = PH_IDLE;
				end else begin
					st_next.phase_cnt = st_reg.phase_cnt + PH_W'(1);
				end
			end
			default: begin
				st_next.phase = PH_IDLE;
			end
		endcase

		if (st_reg.dld_off) begin
			st_next.lock = 1'b0;
			st_next.consec = '0;
		end else if (ph_eval) begin
			if (ph_diff < lock_thr) begin
				if (st_reg.consec != '1) begin
					st_next.consec = st_reg.consec + PH_W'(1);
				end
				if (st_reg.consec >= lock_target - PH_W'(1)) begin
					st_next.lock = 1'b1;
				end
			end else begin
				st_next.consec = '0;
				if (ph_diff > unlock_thr) begin
					st_next.lock = 1'b0;
				end
			end
		end

		////////////////////////////////////////////////////////////////////
		// Current-source indication and pin comparator
		// dedicated selector code
		cs_mode = (st_reg.ld_sel == SEL_CURRENT);
		// any false cycle discharges at once
		if (cs_mode && st_reg.lock) begin
			if (st_reg.charge != '1) begin
				st_next.charge = st_reg.charge + CHG_W'(1);
			end
		end else begin
			st_next.charge = '0;
		end
		cmp_level = cs_mode ? (st_reg.charge >= CHARGE_TERM) : st_reg.ld_pin;

		if (cs_mode) begin
			st_next.ld_pin = st_reg.lock;
		end else begin
			st_next.ld_pin = pin_mux(st_reg.ld_sel, st_reg.lock, 1'b0, st_reg.pfd_ref, st_reg.pfd_fb);
		end
		st_next.status_pin = pin_mux(st_reg.status_sel, st_reg.lock, cmp_level, st_reg.pfd_ref,
			st_reg.pfd_fb);
		st_next.reference_monitor_pin_pin = pin_mux({1'b0, st_reg.reference_monitor_pin_sel}, st_reg.lock, cmp_level, st_reg.pfd_ref,
			st_reg.pfd_fb);

		////////////////////////////////////////////////////////////////////
		// Register writes
		if (wr_en) begin
			case (addr)
				REG_R_LO: st_next.r_div[DATA_W-1:0] = wdata;
				REG_R_HI: st_next.r_div[R_W-1:DATA_W] = wdata[R_HI_W-1:0];
				REG_A: st_next.a_cfg = wdata[A_W-1:0];
				REG_B_LO: st_next.b_cfg[DATA_W-1:0] = wdata;
				REG_B_HI: st_next.b_cfg[B_W-1:DATA_W] = wdata[B_HI_W-1:0];
				REG_PRESC: begin
					st_next.presc_mode = wdata[PRESC_MODE_LSB +: 3];
					st_next.rst_ab = wdata[RST_AB_BIT];
					st_next.rst_r = wdata[RST_R_BIT];
					st_next.rst_all = wdata[RST_ALL_BIT];
				end
				REG_ABP_STATUS: begin
					st_next.abp = wdata[ABP_LSB +: 2];
					st_next.status_sel = wdata[STATUS_SEL_LSB +: 6];
				end
				REG_LOCK_DET: begin
					st_next.dld_off = wdata[DLD_OFF_BIT];
					st_next.ld_window = wdata[LD_WINDOW_BIT];
					st_next.ld_count = wdata[LD_COUNT_LSB +: 2];
				end
				REG_DELAY_SYNC: begin
					st_next.n_dly = wdata[N_DLY_LSB +: 3];
					st_next.r_dly = wdata[R_DLY_LSB +: 3];
					st_next.sync_ctl = wdata[SYNC_CTL_LSB +: 2];
				end
				REG_LD_SEL: st_next.ld_sel = wdata[LD_SEL_LSB +: 6];
				REG_REFERENCE_MONITOR_PIN_SEL: st_next.reference_monitor_pin_sel = wdata[REFERENCE_MONITOR_PIN_SEL_LSB +: 5];
				REG_DELAY_EN: begin
					st_next.r_dly_en = wdata[R_DLY_EN_BIT];
					st_next.n_dly_en = wdata[N_DLY_EN_BIT];
				end
				default: begin
				end
			endcase
		end

		////////////////////////////////////////////////////////////////////
		// Register reads; unmapped addresses read zero
		rd_value = '0;
		case (addr)
			REG_R_LO: rd_value = st_reg.r_div[DATA_W-1:0];
			REG_R_HI: rd_value[R_HI_W-1:0] = st_reg.r_div[R_W-1:DATA_W];
			REG_A: rd_value[A_W-1:0] = st_reg.a_cfg;
			REG_B_LO: rd_value = st_reg.b_cfg[DATA_W-1:0];
			REG_B_HI: rd_value[B_HI_W-1:0] = st_reg.b_cfg[B_W-1:DATA_W];
			REG_PRESC: begin
				rd_value[PRESC_MODE_LSB +: 3] = st_reg.presc_mode;
				rd_value[RST_AB_BIT] = st_reg.rst_ab;
				rd_value[RST_R_BIT] = st_reg.rst_r;
				rd_value[RST_ALL_BIT] = st_reg.rst_all;
			end
			REG_ABP_STATUS: begin
				rd_value[ABP_LSB +: 2] = st_reg.abp;
				rd_value[STATUS_SEL_LSB +: 6] = st_reg.status_sel;
			end
			REG_LOCK_DET: begin
				rd_value[DLD_OFF_BIT] = st_reg.dld_off;
				rd_value[LD_WINDOW_BIT] = st_reg.ld_window;
				rd_value[LD_COUNT_LSB +: 2] = st_reg.ld_count;
			end
			REG_DELAY_SYNC: begin
				rd_value[N_DLY_LSB +: 3] = st_reg.n_dly;
				rd_value[R_DLY_LSB +: 3] = st_reg.r_dly;
				rd_value[SYNC_CTL_LSB +: 2] = st_reg.sync_ctl;
			end
			REG_LD_SEL: rd_value[LD_SEL_LSB +: 6] = st_reg.ld_sel;
			REG_REFERENCE_MONITOR_PIN_SEL: rd_value[REFERENCE_MONITOR_PIN_SEL_LSB +: 5] = st_reg.reference_monitor_pin_sel;
			REG_DELAY_EN: begin
				rd_value[R_DLY_EN_BIT] = st_reg.r_dly_en;
				rd_value[N_DLY_EN_BIT] = st_reg.n_dly_en;
			end
			REG_STATE: begin
				rd_value[ST_LOCK_BIT] = st_reg.lock;
				rd_value[ST_BUSY_BIT] = (st_reg.phase != PH_IDLE);
				rd_value[ST_CMP_BIT] = cmp_level;
			end
			default: rd_value = '0;
		endcase
		st_next.rdata = rd_en ? rd_value : '0;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register
	// divider outputs to detector
	assign pfd_ref_pulse = st_reg.pfd_ref;
	assign pfd_fb_pulse = st_reg.pfd_fb;
	assign digital_lock_indicator = st_reg.lock;
	assign lock_indicator_pin = st_reg.ld_pin;
	assign status_pin = st_reg.status_pin;
	assign reference_monitor_pin = st_reg.reference_monitor_pin_pin;
	assign rdata = st_reg.rdata;

endmodule // pll_divider_lock_detect

//--- hdl/pll_div_pkg.sv
package pll_div_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus and counter widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int R_W = 14;
	localparam int A_W = 6;
	localparam int B_W = 13;
	localparam int PRE_W = 6;
	localparam int PH_W = 8;
	localparam int CHG_W = 16;
	localparam int DLY_TAPS = 8;

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [ADDR_W-1:0] REG_R_LO = 8'h11;
	localparam logic [ADDR_W-1:0] REG_R_HI = 8'h12;
	localparam logic [ADDR_W-1:0] REG_A = 8'h13;
	localparam logic [ADDR_W-1:0] REG_B_LO = 8'h14;
	localparam logic [ADDR_W-1:0] REG_B_HI = 8'h15;
	localparam logic [ADDR_W-1:0] REG_PRESC = 8'h16;
	localparam logic [ADDR_W-1:0] REG_ABP_STATUS = 8'h17;
	localparam logic [ADDR_W-1:0] REG_LOCK_DET = 8'h18;
	localparam logic [ADDR_W-1:0] REG_DELAY_SYNC = 8'h19;
	localparam logic [ADDR_W-1:0] REG_LD_SEL = 8'h1a;
	localparam logic [ADDR_W-1:0] REG_REFERENCE_MONITOR_PIN_SEL = 8'h1b;
	localparam logic [ADDR_W-1:0] REG_DELAY_EN = 8'h1e;
	localparam logic [ADDR_W-1:0] REG_STATE = 8'h20;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int R_HI_W = R_W - DATA_W;
	localparam int B_HI_W = B_W - DATA_W;
	localparam int PRESC_MODE_LSB = 0;
	localparam int RST_AB_BIT = 5;
	localparam int RST_R_BIT = 6;
	localparam int RST_ALL_BIT = 7;
	localparam int ABP_LSB = 0;
	localparam int STATUS_SEL_LSB = 2;
	localparam int DLD_OFF_BIT = 3;
	localparam int LD_WINDOW_BIT = 4;
	localparam int LD_COUNT_LSB = 5;
	localparam int N_DLY_LSB = 0;
	localparam int R_DLY_LSB = 3;
	localparam int SYNC_CTL_LSB = 6;
	localparam int LD_SEL_LSB = 0;
	localparam int REFERENCE_MONITOR_PIN_SEL_LSB = 0;
	localparam int R_DLY_EN_BIT = 0;
	localparam int N_DLY_EN_BIT = 1;
	localparam int ST_LOCK_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_CMP_BIT = 2;

	////////////////////////////////////////////////////////////////////////
	// Prescaler mode codes
	localparam logic [2:0] PRESC_FD1 = 3'h0;
	localparam logic [2:0] PRESC_FD2 = 3'h1;
	localparam logic [2:0] PRESC_DM2 = 3'h2;
	localparam logic [2:0] PRESC_DM4 = 3'h3;
	localparam logic [2:0] PRESC_DM8 = 3'h4;
	localparam logic [2:0] PRESC_DM16 = 3'h5;
	localparam logic [2:0] PRESC_DM32 = 3'h6;
	localparam logic [2:0] PRESC_FD3 = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// Lock detect, sync and pin selector codes
	localparam logic [1:0] SYNC_OFF = 2'h0;
	localparam logic [PH_W-1:0] LOCK_CNT_0 = 8'h05;
	localparam logic [PH_W-1:0] LOCK_CNT_1 = 8'h10;
	localparam logic [PH_W-1:0] LOCK_CNT_2 = 8'h40;
	localparam logic [PH_W-1:0] LOCK_CNT_3 = 8'hff;
	localparam logic [PH_W-1:0] LOCK_THR_HIGH_DEF = 8'h06;
	localparam logic [PH_W-1:0] LOCK_THR_LOW_DEF = 8'h02;
	localparam logic [PH_W-1:0] UNLOCK_MARGIN_DEF = 8'h04;
	localparam logic [CHG_W-1:0] CHARGE_TERM_DEF = 16'h0400;
	localparam logic [5:0] SEL_LOW = 6'h00;
	localparam logic [5:0] SEL_DLD = 6'h01;
	localparam logic [5:0] SEL_DLD_N = 6'h02;
	localparam logic [5:0] SEL_CMP = 6'h03;
	localparam logic [5:0] SEL_CURRENT = 6'h04;
	localparam logic [5:0] SEL_CMP_N = 6'h05;
	localparam logic [5:0] SEL_PFD_REF = 6'h06;
	localparam logic [5:0] SEL_PFD_FB = 6'h07;

	typedef enum logic [1:0] {PH_IDLE, PH_WAIT_FB, PH_WAIT_REF} phase_e;

endpackage

//--- testbench/pll_divider_lock_detect_assertions.sv
`timescale 1ns/10ps
module pll_divider_lock_detect_assertions (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [pll_div_pkg::ADDR_W-1:0] addr,
	input wire logic [pll_div_pkg::DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [pll_div_pkg::DATA_W-1:0] rdata,
	input wire logic ref_clk_in,
	input wire logic vco_clk_in,
	input wire logic nsync_pin,
	input wire logic pfd_ref_pulse,
	input wire logic pfd_fb_pulse,
	input wire logic digital_lock_indicator,
	input wire logic lock_indicator_pin,
	input wire logic status_pin,
	input wire logic reference_monitor_pin
);
	import pll_div_pkg::*;
	logic [5:0] ld_sel;
	logic rst_all, sync_en;
	logic [4:0] ld_age, cfg_age, ns_age, p_age;
	function automatic logic [4:0] up(input logic [4:0] v);
		return (v == 5'h1f) ? v : v + 5'h01;
	endfunction
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	// Snooped settings; ages saturate so long holds stay visible
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ld_sel <= '0;
			rst_all <= 1'b0;
			sync_en <= 1'b0;
			ld_age <= '0;
			cfg_age <= '0;
		end else begin
			ld_age <= up(ld_age);
			cfg_age <= up(cfg_age);
			if (wr_en && addr == REG_LD_SEL) begin
				ld_sel <= wdata[5:0];
				ld_age <= '0;
			end
			if (wr_en && addr == REG_PRESC) begin
				rst_all <= wdata[RST_ALL_BIT];
				cfg_age <= '0;
			end
			if (wr_en && addr == REG_DELAY_SYNC) begin
				sync_en <= |wdata[7:6];
				cfg_age <= '0;
			end
		end
		ns_age <= (nsync_pin || !nrst) ? '0 : up(ns_age);
		p_age <= (pfd_ref_pulse || pfd_fb_pulse) ? '0 : up(p_age);
	end
	////////////////////////////////////////
	ref_one_a: assert property (pfd_ref_pulse |=> !pfd_ref_pulse)
		else $error("reference pulse longer than one cycle");
	fb_one_a: assert property (pfd_fb_pulse |=> !pfd_fb_pulse)
		else $error("feedback pulse longer than one cycle");
	rdata_idle_a: assert property (!$past(rd_en) |-> rdata == '0)
		else $error("read data outside read slot");
	lock_rise_a: assert property ($rose(digital_lock_indicator) |-> p_age <= 5'd6)
		else $error("lock rose far from any detector pulse");
	pin_follow_a: assert property ((ld_age > 5'd2 && (ld_sel == SEL_DLD || ld_sel == SEL_CURRENT))
		|-> lock_indicator_pin == digital_lock_indicator || lock_indicator_pin == $past(digital_lock_indicator))
		else $error("lock pin does not follow lock");
	pin_low_a: assert property ((ld_age > 5'd2 && ld_sel == SEL_LOW) |-> !lock_indicator_pin)
		else $error("lock pin high while selected low");
	current_drop_a: assert property ((ld_sel == SEL_CURRENT && ld_age > 5'd2 && $fell(digital_lock_indicator))
		|-> ##[0:1] !lock_indicator_pin)
		else $error("current mode pin not grounded on unlock");
	shared_hold_a: assert property ((rst_all && cfg_age > 5'd15) |-> !pfd_ref_pulse && !pfd_fb_pulse)
		else $error("pulse while shared reset held");
	sync_hold_a: assert property ((sync_en && ns_age > 5'd15 && cfg_age > 5'd15)
		|-> !pfd_ref_pulse && !pfd_fb_pulse)
		else $error("pulse while sync pin reset held");
endmodule // pll_divider_lock_detect_assertions

bind pll_divider_lock_detect pll_divider_lock_detect_assertions pll_divider_lock_detect_assertions_inst (
	.mclk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .ref_clk_in, .vco_clk_in, .nsync_pin,
	.pfd_ref_pulse, .pfd_fb_pulse, .digital_lock_indicator, .lock_indicator_pin, .status_pin, .reference_monitor_pin
);

//--- testbench/pll_divider_lock_detect_tb.sv
`timescale 1ns/10ps
module pll_divider_lock_detect_tb;
	import pll_div_pkg::*;
	typedef struct {logic [2:0] m; logic [5:0] a; logic [7:0] b; logic [13:0] r; int nf; int nr;} row_s;
	logic mclk, nrst, wr_en, rd_en, ref_clk_in, vco_clk_in, nsync_pin, vco_run, vco_ph;
	logic [7:0] addr, wdata, rdata;
	logic pfd_ref_pulse, pfd_fb_pulse, digital_lock_indicator, lock_indicator_pin, status_pin, reference_monitor_pin;
	logic [1:0] tcyc = 2'h0;
	logic [1:0] s;
	int err_count, compares, n, k;
	row_s rows [8] = '{'{PRESC_FD1, 6'h05, 8'h01, 14'h0, 1, 1}, '{PRESC_FD2, 6'h03, 8'h03, 14'h1, 6, 1},
		'{PRESC_DM2, 6'h01, 8'h03, 14'h2, 7, 2}, '{PRESC_DM4, 6'h00, 8'h03, 14'h3, 12, 3},
		'{PRESC_DM8, 6'h02, 8'h03, 14'h101, 26, 257}, '{PRESC_DM16, 6'h01, 8'h04, 14'h5, 65, 5},
		'{PRESC_DM32, 6'h00, 8'h03, 14'h0, 96, 1}, '{PRESC_FD3, 6'h09, 8'h01, 14'h4, 3, 4}};
	// Fields: 0x16, 0x19, sync pin level, pulses expected {ref, fb}
	logic [19:0] hold [5] = '{20'h80000, 20'h40005, 20'h20006, 20'h00400, 20'h00003};

	pll_divider_lock_detect #(.CHARGE_TERM(16'h0008)) pll_divider_lock_detect_inst (
		.mclk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .ref_clk_in, .vco_clk_in, .nsync_pin,
		.pfd_ref_pulse, .pfd_fb_pulse, .digital_lock_indicator, .lock_indicator_pin, .status_pin, .reference_monitor_pin
	);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// Both inputs at a quarter of mclk; vco may be stopped or shifted two cycles
	always @(posedge mclk) begin
		tcyc <= tcyc + 2'h1;
		ref_clk_in <= tcyc[1];
		vco_clk_in <= vco_run & (tcyc[1] ^ vco_ph);
	end
	////////////////////////////////////////
	task automatic step();
		@(posedge mclk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 chk("rdata", 32'(rdata & m), 32'(e));
	endtask
	task automatic wait_p(input bit fb, output int c);
		c = 0;
		do begin
			step();
			c++;
		end while ((fb ? pfd_fb_pulse : pfd_ref_pulse) !== 1'b1 && c < 5000);
	endtask
	task automatic pins(input logic [2:0] e);
		chk("pins", 32'({lock_indicator_pin, status_pin, reference_monitor_pin}), 32'(e));
	endtask
	task automatic tally_and_finish();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		tally_and_finish();
	end
	initial begin
		{nrst, wr_en, rd_en, vco_ph} = 4'h0;
		{addr, wdata} = 16'h0000;
		nsync_pin = 1'b1;
		vco_run = 1'b1;
		err_count = 0;
		compares = 0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			wr(REG_PRESC, {5'h10, rows[i].m});
			wr(REG_R_LO, rows[i].r[7:0]);
			wr(REG_R_HI, {2'h0, rows[i].r[13:8]});
			wr(REG_A, {2'h0, rows[i].a});
			wr(REG_B_LO, rows[i].b);
			wr(REG_B_HI, 8'h00);
			wr(REG_PRESC, {5'h00, rows[i].m});
			wait_p(1'b1, n);
			wait_p(1'b1, n);
			chk("fb_period", n, rows[i].nf * 4);
			wait_p(1'b0, n);
			wait_p(1'b0, n);
			chk("ref_period", n, rows[i].nr * 4);
		end
		$display("divider rows done");
		vco_run <= 1'b0;
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		wr(8'h1c, 8'hff);
		for (k = 8'h11; k <= 8'h20; k++) rd(8'(k), 8'h00, (k == 8'h20) ? 8'hfd : 8'hff);
		$display("reset values done");
		// Detector period of 12 cycles stays above both unlock windows
		wr(REG_R_LO, 8'h03);
		wr(REG_B_LO, 8'h03);
		// Shared reset lines up both dividers on restart
		wr(REG_PRESC, 8'h80);
		vco_run <= 1'b1;
		repeat (8) step();
		wr(REG_PRESC, 8'h00);
		wait_p(1'b1, n);
		// First pair closes with the first feedback pulse
		n = 1;
		for (k = 0; k < 200 && digital_lock_indicator !== 1'b1; k++) begin
			step();
			n += int'(pfd_ref_pulse === 1'b1);
		end
		chk("lock_pairs", n, 5);
		wr(REG_LD_SEL, {2'h0, SEL_CURRENT});
		wr(REG_ABP_STATUS, {SEL_CMP, 2'h0});
		wr(REG_REFERENCE_MONITOR_PIN_SEL, {2'h0, SEL_CMP_N});
		repeat (12) step();
		pins(3'b110);
		rd(REG_STATE, 8'h05, 8'h05);
		vco_run <= 1'b0;
		for (k = 0; k < 40 && digital_lock_indicator !== 1'b0; k++) step();
		chk("unlock_fast", 32'(k < 40), 1);
		repeat (4) step();
		pins(3'b001);
		$display("lock and current mode done");
		wr(REG_PRESC, 8'h80);
		vco_ph <= 1'b1;
		vco_run <= 1'b1;
		repeat (8) step();
		wr(REG_PRESC, 8'h00);
		for (k = 0; k < 100 && digital_lock_indicator !== 1'b1; k++) step();
		chk("hi_range_lock", 32'({k < 100, status_pin}), 2);
		repeat (12) step();
		chk("charged", 32'(status_pin), 1);
		wr(REG_LOCK_DET, 8'h10);
		repeat (40) step();
		chk("hyst_keep", 32'(digital_lock_indicator), 1);
		vco_run <= 1'b0;
		repeat (30) step();
		vco_run <= 1'b1;
		repeat (80) step();
		chk("lo_range_lock", 32'(digital_lock_indicator), 0);
		wr(REG_LOCK_DET, 8'h00);
		vco_ph <= 1'b0;
		$display("window done");
		foreach (hold[j]) begin
			@(posedge mclk);
			nsync_pin <= hold[j][2];
			wr(REG_PRESC, hold[j][19:12]);
			wr(REG_DELAY_SYNC, hold[j][11:4]);
			repeat (16) step();
			s = 2'b00;
			repeat (24) begin
				step();
				s = s | {pfd_ref_pulse, pfd_fb_pulse};
			end
			chk("pulses_seen", 32'(s), 32'(hold[j][1:0]));
		end
		$display("counter resets done");
		@(posedge mclk);
		nsync_pin <= 1'b1;
		wr(REG_DELAY_SYNC, 8'h08);
		wr(REG_DELAY_EN, 8'h01);
		repeat (16) step();
		wait_p(1'b1, n);
		wait_p(1'b0, n);
		chk("ref_delay", n, 2);
		wr(REG_LD_SEL, {2'h0, SEL_DLD_N});
		wr(REG_ABP_STATUS, {SEL_DLD, 2'h0});
		wr(REG_REFERENCE_MONITOR_PIN_SEL, {2'h0, SEL_PFD_REF});
		// Room to relock if the delay switch split a pair
		repeat (64) step();
		wait_p(1'b0, n);
		step();
		pins(3'b011);
		$display("delay done");
		tally_and_finish();
	end
endmodule // pll_divider_lock_detect_tb
